// [design/i2c_regs_pkg.sv]
// package: register map, field positions, reset values and carriers of the two-wire bus register block
package i2c_regs_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CONTROL     = 8'h64;
	localparam logic [7:0] IDX_STATUS_ONE  = 8'h65;
	localparam logic [7:0] IDX_STATUS_TWO  = 8'h66;
	localparam logic [7:0] IDX_CLOCK_CTRL  = 8'h67;
	localparam logic [7:0] IDX_OWN_LOW     = 8'h68;
	localparam logic [7:0] IDX_OWN_HIGH    = 8'h69;
	localparam logic [7:0] IDX_DATA        = 8'h6a;
	localparam logic [7:0] IDX_MODE        = 8'h6b;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTL_ENABLE       = 5;
	localparam int CTL_GC_ENABLE    = 4;
	localparam int CTL_START        = 3;
	localparam int CTL_ACK          = 2;
	localparam int CTL_STOP         = 1;
	localparam int CTL_IRQ_ENABLE   = 0;
	localparam int CLK_FAST         = 7;
	localparam int OWN_HIGH_FREQ_LO = 6;
	localparam int MODE_TEN_BIT     = 0;

	// ----------------------------------------------------------------
	// reset values and masks
	// ----------------------------------------------------------------
	localparam logic [7:0] CONTROL_RST    = 8'h00;
	localparam logic [7:0] CLOCK_RST      = 8'h00;
	localparam logic [7:0] OWN_LOW_RST    = 8'h00;
	localparam logic [7:0] OWN_HIGH_RST   = 8'h40;
	localparam logic [7:0] DATA_RST       = 8'h00;
	localparam logic [7:0] CONTROL_MASK   = 8'h3f;
	localparam logic [7:0] OWN_HIGH_MASK  = 8'hc6;
	localparam logic [7:0] GENERAL_CALL   = 8'h00;
	localparam logic [7:0] NEVER_ANSWERED = 8'h01;
	localparam logic [4:0] TEN_BIT_HEADER = 5'h1e;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       start_sent;
		logic       byte_done;
		logic       ack_failure;
		logic       stop_detected;
		logic       arb_lost;
		logic       bus_error;
		logic       rx_ack_phase;
		logic       addr_valid;
		logic       rx_byte_valid;
		logic [7:0] rx_byte;
	} bus_events_s;

	typedef struct packed {
		logic       own_match;
		logic       general_call;
	} addr_result_s;

endpackage

// [design/scl_rate_divider.sv]
// module: divider that turns the clock-control setting into an scl half-period enable pulse
`timescale 1ns/10ps
`default_nettype none
module scl_rate_divider #(
	parameter int DIV_W = 9
) (
	input  wire logic       sys_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       run_i,
	input  wire logic       fast_speed_select_i,
	input  wire logic [6:0] clock_divider_i,
	output logic            scl_tick_o
);
	logic [DIV_W-1:0] count;
	logic [DIV_W-1:0] limit;

	// standard speed takes twice the half-period of fast speed
	always_comb begin
		if (fast_speed_select_i) begin
			limit = DIV_W'({2'b00, clock_divider_i});
		end else begin
			limit = DIV_W'({1'b0, clock_divider_i, 1'b1});
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count      <= '0;
			scl_tick_o <= 1'b0;
		end else if (!run_i) begin
			count      <= '0;
			scl_tick_o <= 1'b0;
		end else if (count >= limit) begin
			count      <= '0;
			scl_tick_o <= 1'b1;
		end else begin
			count      <= count + DIV_W'(1);
			scl_tick_o <= 1'b0;
		end
	end
endmodule // scl_rate_divider
`default_nettype wire

// [design/own_address_matcher.sv]
// module: compares received address bytes with the own address in seven- or ten-bit form
`timescale 1ns/10ps
`default_nettype none
module own_address_matcher (
	input  wire logic                        sys_clk_i,
	input  wire logic                        resetn_i,
	input  wire logic                        addr_valid_i,
	input  wire logic [7:0]                  addr_byte_i,
	input  wire logic                        ten_bit_i,
	input  wire logic                        general_call_enable_i,
	input  wire logic [7:0]                  own_low_i,
	input  wire logic [1:0]                  own_top_i,
	output var i2c_regs_pkg::addr_result_s   result_o
);
	logic header_seen;
	logic header_hit;
	logic low_hit;

	assign header_hit = (addr_byte_i[7:3] == i2c_regs_pkg::TEN_BIT_HEADER) && (addr_byte_i[2:1] == own_top_i);
	assign low_hit    = (addr_byte_i[7:1] == own_low_i[7:1]) && (addr_byte_i != i2c_regs_pkg::NEVER_ANSWERED);

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			header_seen <= 1'b0;
			result_o    <= '0;
		end else if (addr_valid_i) begin
			header_seen           <= ten_bit_i && !header_seen && header_hit;
			result_o.general_call <= general_call_enable_i && !header_seen
				&& (addr_byte_i == i2c_regs_pkg::GENERAL_CALL);
			if (ten_bit_i) begin
				result_o.own_match <= header_seen && (addr_byte_i == own_low_i);
			end else begin
				result_o.own_match <= low_hit;
			end
		end else begin
			result_o <= '0;
		end
	end
endmodule // own_address_matcher
`default_nettype wire

// [design/i2c_status_clock_address_regs.sv]
// module: status, clock control, data and own-address registers of the two-wire bus interface
`timescale 1ns/10ps
`default_nettype none
module i2c_status_clock_address_regs #(
	parameter int ADDR_W = 12
) (
	input  wire logic                       sys_clk_i,
	input  wire logic                       resetn_i,
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [ADDR_W-1:0]          wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic      [31:0]                wb_dat_o,
	output logic                            wb_ack_o,
	input  wire i2c_regs_pkg::bus_events_s  bus_events_i,
	input  wire logic                       transmitter_role_i,
	input  wire logic                       cpu_irq_mask_i,
	output logic                            irq_o,
	output logic                            scl_hold_o,
	output logic                            scl_tick_o,
	output logic                            tx_start_o,
	output logic      [7:0]                 tx_byte_o,
	output logic                            rx_allow_o,
	output logic                            address_ack_o,
	output logic                            master_mode_flag_o,
	output logic                            start_request_o,
	output logic                            stop_request_o,
	output logic                            ack_enable_o,
	output logic      [1:0]                 delay_frequency_code_o
);
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [7:0] bus_control;
	logic [7:0] bus_clock_control;
	logic [7:0] own_address_low;
	logic [7:0] own_address_high_freq;
	logic [7:0] bus_data;
	logic       ten_bit_mode;
	logic       ack_failure_flag;
	logic       stop_detected_flag;
	logic       arbitration_lost_flag;
	logic       bus_error_flag;
	logic       general_call_flag;
	logic       start_sent_flag;
	logic       byte_finished_flag;
	logic       master_mode_flag;
	logic       status_one_seen;
	logic       rx_allow;

	logic       interface_enable;
	logic       interrupt_enable;
	logic       general_call_enable;
	logic       any_event;
	logic [7:0] bus_status_one;
	logic [7:0] bus_status_two;

	i2c_regs_pkg::addr_result_s addr_result;

	assign interface_enable    = bus_control[i2c_regs_pkg::CTL_ENABLE];
	assign interrupt_enable    = bus_control[i2c_regs_pkg::CTL_IRQ_ENABLE];
	assign general_call_enable = bus_control[i2c_regs_pkg::CTL_GC_ENABLE];

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	logic       req;
	logic       fire;
	logic       wr_lane;
	logic [7:0] index;
	logic       index_ok;
	logic [7:0] rd_data;

	assign req      = wb_cyc_i && wb_stb_i;
	assign fire     = req && wb_ack_o;
	assign wr_lane  = fire && wb_we_i && wb_sel_i[0];
	assign index    = wb_adr_i[9:2];
	assign index_ok = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i[ADDR_W-1:10] == '0);

	logic wr_control;
	logic wr_clock;
	logic wr_own_low;
	logic wr_own_high;
	logic wr_data;
	logic wr_mode;
	logic rd_status_one;
	logic rd_status_two;
	logic rd_data_reg;

	assign wr_control    = wr_lane && index_ok && (index == i2c_regs_pkg::IDX_CONTROL);
	assign wr_clock      = wr_lane && index_ok && (index == i2c_regs_pkg::IDX_CLOCK_CTRL);
	assign wr_own_low    = wr_lane && index_ok && (index == i2c_regs_pkg::IDX_OWN_LOW);
	assign wr_own_high   = wr_lane && index_ok && (index == i2c_regs_pkg::IDX_OWN_HIGH);
	assign wr_data       = wr_lane && index_ok && (index == i2c_regs_pkg::IDX_DATA);
	assign wr_mode       = wr_lane && index_ok && (index == i2c_regs_pkg::IDX_MODE);
	assign rd_status_one = fire && !wb_we_i && index_ok && (index == i2c_regs_pkg::IDX_STATUS_ONE);
	assign rd_status_two = fire && !wb_we_i && index_ok && (index == i2c_regs_pkg::IDX_STATUS_TWO);
	assign rd_data_reg   = fire && !wb_we_i && index_ok && (index == i2c_regs_pkg::IDX_DATA);

	// unmapped addresses are acknowledged and read as zero
	always_comb begin
		rd_data = 8'h00;
		if (index_ok) begin
			case (index)
				i2c_regs_pkg::IDX_CONTROL:    rd_data = bus_control;
				i2c_regs_pkg::IDX_STATUS_ONE: rd_data = bus_status_one;
				i2c_regs_pkg::IDX_STATUS_TWO: rd_data = bus_status_two;
				i2c_regs_pkg::IDX_CLOCK_CTRL: rd_data = bus_clock_control;
				i2c_regs_pkg::IDX_OWN_LOW:    rd_data = own_address_low;
				i2c_regs_pkg::IDX_OWN_HIGH:   rd_data = own_address_high_freq;
				i2c_regs_pkg::IDX_DATA:       rd_data = bus_data;
				i2c_regs_pkg::IDX_MODE:       rd_data = {7'h00, ten_bit_mode};
				default:                      rd_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req && !wb_ack_o;
			if (req && !wb_ack_o) begin
				wb_dat_o <= {24'h00_0000, rd_data};
			end
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bus_control <= i2c_regs_pkg::CONTROL_RST;
		end else if (wr_control && !interface_enable) begin
			// first enabling write takes only the enable; stop bit survives
			bus_control[i2c_regs_pkg::CTL_ENABLE] <= wb_dat_i[i2c_regs_pkg::CTL_ENABLE];
		end else if (wr_control) begin
			bus_control <= wb_dat_i[7:0] & i2c_regs_pkg::CONTROL_MASK;
			if (!wb_dat_i[i2c_regs_pkg::CTL_ENABLE]) begin
				bus_control <= i2c_regs_pkg::CONTROL_RST;
				bus_control[i2c_regs_pkg::CTL_STOP] <= wb_dat_i[i2c_regs_pkg::CTL_STOP];
			end
		end else begin
			if (bus_events_i.start_sent) begin
				bus_control[i2c_regs_pkg::CTL_START] <= 1'b0;
			end
			if (master_mode_flag && bus_events_i.stop_detected) begin
				bus_control[i2c_regs_pkg::CTL_STOP] <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// clock control, own address, mode
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bus_clock_control <= i2c_regs_pkg::CLOCK_RST;
		end else if (wr_clock) begin
			bus_clock_control <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			own_address_low <= i2c_regs_pkg::OWN_LOW_RST;
			ten_bit_mode    <= 1'b0;
		end else begin
			if (wr_own_low) begin
				own_address_low <= wb_dat_i[7:0];
			end
			if (wr_mode) begin
				ten_bit_mode <= wb_dat_i[i2c_regs_pkg::MODE_TEN_BIT];
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			own_address_high_freq <= i2c_regs_pkg::OWN_HIGH_RST;
		end else if (wr_own_high) begin
			own_address_high_freq[2:1] <= wb_dat_i[2:1];
			if (!interface_enable) begin
				own_address_high_freq[7:6] <= wb_dat_i[7:6];
			end
		end
	end

	assign delay_frequency_code_o = own_address_high_freq[7:6];

	// ----------------------------------------------------------------
	// data register and transfer flow
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bus_data   <= i2c_regs_pkg::DATA_RST;
			tx_start_o <= 1'b0;
		end else begin
			tx_start_o <= wr_data && transmitter_role_i && interface_enable;
			if (wr_data) begin
				bus_data <= wb_dat_i[7:0];
			end else if (bus_events_i.rx_byte_valid && rx_allow) begin
				bus_data <= bus_events_i.rx_byte;
			end
		end
	end

	assign tx_byte_o = bus_data;

	// the first byte after an address is taken freely, later ones wait for a read
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_allow <= 1'b0;
		end else if (!interface_enable) begin
			rx_allow <= 1'b0;
		end else if (bus_events_i.addr_valid || rd_data_reg) begin
			rx_allow <= 1'b1;
		end else if (bus_events_i.rx_byte_valid) begin
			rx_allow <= 1'b0;
		end
	end

	assign rx_allow_o = rx_allow && !transmitter_role_i;

	// ----------------------------------------------------------------
	// status two flags (set wins over clear)
	// ----------------------------------------------------------------
	logic set_af;
	logic set_stop;
	logic set_arbitration_lost_flag;
	logic set_bus_error_flag;

	assign set_af   = interface_enable && bus_events_i.ack_failure;
	assign set_stop = interface_enable && bus_events_i.stop_detected && !master_mode_flag
		&& bus_control[i2c_regs_pkg::CTL_ACK];
	assign set_arbitration_lost_flag = interface_enable && bus_events_i.arb_lost && master_mode_flag
		&& !(bus_events_i.rx_ack_phase && !transmitter_role_i);
	assign set_bus_error_flag = interface_enable && bus_events_i.bus_error;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_failure_flag      <= 1'b0;
			stop_detected_flag    <= 1'b0;
			arbitration_lost_flag <= 1'b0;
			bus_error_flag        <= 1'b0;
		end else if (!interface_enable) begin
			ack_failure_flag      <= 1'b0;
			stop_detected_flag    <= 1'b0;
			arbitration_lost_flag <= 1'b0;
			bus_error_flag        <= 1'b0;
		end else begin
			ack_failure_flag      <= set_af || (ack_failure_flag && !rd_status_two);
			stop_detected_flag    <= set_stop || (stop_detected_flag && !rd_status_two);
			arbitration_lost_flag <= set_arbitration_lost_flag || (arbitration_lost_flag && !rd_status_two);
			bus_error_flag        <= set_bus_error_flag || (bus_error_flag && !rd_status_two);
		end
	end

	// reading does not clear the general call flag
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			general_call_flag <= 1'b0;
		end else if (!interface_enable) begin
			general_call_flag <= 1'b0;
		end else if (addr_result.general_call && !master_mode_flag) begin
			general_call_flag <= 1'b1;
		end else if (set_stop) begin
			general_call_flag <= 1'b0;
		end
	end

	assign bus_status_two = {3'b000, ack_failure_flag, stop_detected_flag,
		arbitration_lost_flag, bus_error_flag, general_call_flag};

	// ----------------------------------------------------------------
	// status one flags; start-sent and byte-finished hold the clock, master mode does not
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			status_one_seen <= 1'b0;
		end else if (!interface_enable || wr_data || rd_data_reg) begin
			status_one_seen <= 1'b0;
		end else if (rd_status_one) begin
			status_one_seen <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			start_sent_flag    <= 1'b0;
			byte_finished_flag <= 1'b0;
		end else if (!interface_enable) begin
			start_sent_flag    <= 1'b0;
			byte_finished_flag <= 1'b0;
		end else begin
			start_sent_flag <= bus_events_i.start_sent
				|| (start_sent_flag && !(status_one_seen && wr_data));
			byte_finished_flag <= bus_events_i.byte_done
				|| (byte_finished_flag && !(status_one_seen && (wr_data || rd_data_reg)));
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			master_mode_flag <= 1'b0;
		end else if (!interface_enable || set_arbitration_lost_flag || bus_events_i.stop_detected) begin
			master_mode_flag <= 1'b0;
		end else if (wr_control && wb_dat_i[i2c_regs_pkg::CTL_START]) begin
			master_mode_flag <= 1'b1;
		end
	end

	assign bus_status_one = {any_event, 3'b000, byte_finished_flag, 1'b0,
		master_mode_flag, start_sent_flag};

	// clock is held only by start-sent and byte-finished, never by error flags
	assign scl_hold_o = interface_enable && (start_sent_flag || byte_finished_flag);

	// ----------------------------------------------------------------
	// interrupt request
	// ----------------------------------------------------------------
	assign any_event = start_sent_flag || byte_finished_flag || ack_failure_flag
		|| stop_detected_flag || arbitration_lost_flag || bus_error_flag;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= any_event && interrupt_enable && !cpu_irq_mask_i;
		end
	end

	// ----------------------------------------------------------------
	// address match and rate divider
	// ----------------------------------------------------------------
	own_address_matcher u_matcher (
		.sys_clk_i             (sys_clk_i),
		.resetn_i              (resetn_i),
		.addr_valid_i          (bus_events_i.addr_valid && interface_enable),
		.addr_byte_i           (bus_events_i.rx_byte),
		.ten_bit_i             (ten_bit_mode),
		.general_call_enable_i (general_call_enable),
		.own_low_i             (own_address_low),
		.own_top_i             (own_address_high_freq[2:1]),
		.result_o              (addr_result)
	);

	assign address_ack_o = addr_result.own_match || addr_result.general_call;

	scl_rate_divider u_divider (
		.sys_clk_i           (sys_clk_i),
		.resetn_i            (resetn_i),
		.run_i               (interface_enable),
		.fast_speed_select_i (bus_clock_control[i2c_regs_pkg::CLK_FAST]),
		.clock_divider_i     (bus_clock_control[6:0]),
		.scl_tick_o          (scl_tick_o)
	);

	assign master_mode_flag_o = master_mode_flag;
	assign start_request_o    = bus_control[i2c_regs_pkg::CTL_START];
	assign stop_request_o     = bus_control[i2c_regs_pkg::CTL_STOP];
	assign ack_enable_o       = bus_control[i2c_regs_pkg::CTL_ACK];
endmodule // i2c_status_clock_address_regs
`default_nettype wire

// [verification/i2c_regs_monitor.sv]
// checker: port timing relations of the two-wire bus register block
`timescale 1ns/10ps
`default_nettype none
module i2c_regs_monitor #(
	parameter int ADDR_W = 12
) (
	input wire logic                      sys_clk_i,
	input wire logic                      resetn_i,
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_we_i,
	input wire logic [ADDR_W-1:0]         wb_adr_i,
	input wire logic                      wb_ack_o,
	input wire i2c_regs_pkg::bus_events_s bus_events_i,
	input wire logic                      transmitter_role_i,
	input wire logic                      cpu_irq_mask_i,
	input wire logic                      irq_o,
	input wire logic                      scl_hold_o,
	input wire logic                      tx_start_o,
	input wire logic                      address_ack_o,
	input wire logic                      master_mode_flag_o,
	input wire logic [1:0]                delay_frequency_code_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	a_hold_cause: assert property ($rose(scl_hold_o) |-> $past(bus_events_i.start_sent || bus_events_i.byte_done))
		else $error("scl hold without start or byte flag");
	a_addr_ack_cause: assert property (address_ack_o |-> $past(bus_events_i.addr_valid))
		else $error("address ack without address byte");
	a_never_01: assert property (bus_events_i.addr_valid && bus_events_i.rx_byte == 8'h01 |=> !address_ack_o)
		else $error("address 01 answered");
	a_tx_cause: assert property (tx_start_o |-> $past(wb_ack_o && wb_we_i && transmitter_role_i)
		|| $past(wb_ack_o && wb_we_i && transmitter_role_i, 2))
		else $error("transmit start without data write");
	a_arb_to_slave: assert property (bus_events_i.arb_lost && master_mode_flag_o && !bus_events_i.rx_ack_phase
		|=> !master_mode_flag_o)
		else $error("master kept after lost arbitration");
	a_no_ack_arb: assert property (bus_events_i.arb_lost && bus_events_i.rx_ack_phase && !transmitter_role_i
		&& !wb_cyc_i && !bus_events_i.stop_detected |=> $stable(master_mode_flag_o))
		else $error("arbitration during acknowledge bit");
	a_irq_masked: assert property (cpu_irq_mask_i |=> !irq_o)
		else $error("irq while masked");
	a_code_by_write: assert property ($changed(delay_frequency_code_o)
		|-> $past(wb_ack_o && wb_we_i && wb_adr_i == 12'h1a4))
		else $error("delay code changed without write");
	c_irq: cover property (irq_o);
	c_addr_ack: cover property (address_ack_o);
	c_tx_start: cover property (tx_start_o);
endmodule // i2c_regs_monitor
bind i2c_status_clock_address_regs i2c_regs_monitor #(.ADDR_W(ADDR_W)) i_i2c_regs_monitor (.sys_clk_i, .resetn_i,
	.wb_cyc_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .bus_events_i, .transmitter_role_i, .cpu_irq_mask_i, .irq_o,
	.scl_hold_o, .tx_start_o, .address_ack_o, .master_mode_flag_o, .delay_frequency_code_o);
`default_nettype wire

// [verification/bus_party_model.sv]
// model: other bus parties, seen as one-cycle event words
`timescale 1ns/10ps
`default_nettype none
module bus_party_model (
	input  wire logic                     sys_clk_i,
	output var i2c_regs_pkg::bus_events_s bus_events_o
);
	initial bus_events_o = '0;
	// after the pulse the byte lines show the inverse, never the stale byte
	task automatic fire(input logic [8:0] f, input logic [7:0] b, input int slow);
		repeat (slow) @(posedge sys_clk_i);
		@(posedge sys_clk_i);
		bus_events_o <= {f, b};
		@(posedge sys_clk_i);
		bus_events_o <= {9'h000, ~b};
		#1;
	endtask
endmodule // bus_party_model
`default_nettype wire

// [verification/i2c_status_clock_address_regs_tb.sv]
// testbench: registers, event flags, address match and transmit start
`timescale 1ns/10ps
`default_nettype none
module i2c_status_clock_address_regs_tb;
	logic                      sys_clk_i = 1'h0, resetn_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic                      transmitter_role_i = 1'h0, cpu_irq_mask_i = 1'h0;
	logic                      wb_ack_o, irq_o, scl_hold_o, tx_start_o, address_ack_o, master_mode_flag_o;
	logic                      scl_tick_o, rx_allow_o;
	logic [11:0]               wb_adr_i = 12'h000;
	logic [3:0]                wb_sel_i = 4'h1;
	logic [31:0]               wb_dat_i = 32'h0, wb_dat_o;
	logic [7:0]                tx_byte_o, q;
	logic [1:0]                delay_frequency_code_o;
	wire i2c_regs_pkg::bus_events_s bus_events_i;
	int                        err_total = 0, check_count = 0;
	always #10 sys_clk_i = ~sys_clk_i;
	i2c_status_clock_address_regs i_i2c_status_clock_address_regs (.sys_clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .bus_events_i, .transmitter_role_i,
		.cpu_irq_mask_i, .irq_o, .scl_hold_o, .scl_tick_o, .tx_start_o, .tx_byte_o, .rx_allow_o,
		.address_ack_o, .master_mode_flag_o, .start_request_o(), .stop_request_o(), .ack_enable_o(),
		.delay_frequency_code_o);
	bus_party_model i_bus_party_model (.sys_clk_i, .bus_events_o(bus_events_i));
	task automatic ck(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, 2'h0, idx, 2'h0, 24'h0, d};
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (wb_ack_o !== 1'h1 && n < 20);
		ck(wb_ack_o, 8'h01);
		q = wb_dat_o[7:0];
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		wb(1'h0, idx, 8'h00);
		ck(q, exp);
	endtask
	task automatic ev(input logic [8:0] f, input logic [7:0] b);
		i_bus_party_model.fire(f, b, 0);
	endtask
	task automatic t_regs;
		ck(delay_frequency_code_o, 8'h01);
		rd(8'h66, 8'h00);
		rd(8'h69, 8'h40);
		rd(8'h6a, 8'h00);
		rd(8'h70, 8'h00);
		wb(1'h1, 8'h67, 8'hff);
		rd(8'h67, 8'hff);
		wb(1'h1, 8'h69, 8'hff);
		rd(8'h69, 8'hc6);
		ck(delay_frequency_code_o, 8'h03);
		wb(1'h1, 8'h64, 8'h20);
		wb(1'h1, 8'h69, 8'h00);
		wb(1'h1, 8'h64, 8'h00);
		rd(8'h69, 8'hc0);
		rd(8'h67, 8'hff);
		wb(1'h1, 8'h69, 8'h40);
		wb(1'h1, 8'h68, 8'h5a);
		$display("test regs done");
	endtask
	task automatic t_flags;
		wb(1'h1, 8'h64, 8'h20);
		wb(1'h1, 8'h64, 8'h25);
		ev(9'h040, 8'h00);
		ck(scl_hold_o, 8'h00);
		i_bus_party_model.fire(9'h008, 8'h00, 3);
		ck(scl_hold_o, 8'h00);
		ev(9'h020, 8'h00);
		ck(scl_hold_o, 8'h00);
		@(posedge sys_clk_i);
		cpu_irq_mask_i <= 1'h1;
		#1 ck(irq_o, 8'h01);
		repeat (2) @(posedge sys_clk_i);
		cpu_irq_mask_i <= 1'h0;
		#1 ck(irq_o, 8'h00);
		rd(8'h66, 8'h1a);
		rd(8'h66, 8'h00);
		$display("test flags done");
	endtask
	task automatic t_gcall;
		wb(1'h1, 8'h64, 8'h35);
		ev(9'h002, 8'h00);
		ck(address_ack_o, 8'h01);
		rd(8'h66, 8'h01);
		rd(8'h66, 8'h01);
		wb(1'h1, 8'h68, 8'h00);
		ev(9'h002, 8'h01);
		ck(address_ack_o, 8'h00);
		wb(1'h1, 8'h68, 8'h5a);
		ev(9'h002, 8'h5b);
		ck(address_ack_o, 8'h01);
		ev(9'h020, 8'h00);
		rd(8'h66, 8'h08);
		ev(9'h040, 8'h00);
		wb(1'h1, 8'h64, 8'h00);
		rd(8'h66, 8'h00);
		$display("test general call done");
	endtask
	task automatic t_arb;
		wb(1'h1, 8'h64, 8'h20);
		wb(1'h1, 8'h64, 8'h2c);
		#1 ck(master_mode_flag_o, 8'h01);
		ev(9'h014, 8'h00);
		ck(master_mode_flag_o, 8'h01);
		rd(8'h66, 8'h00);
		ev(9'h010, 8'h00);
		ck(master_mode_flag_o, 8'h00);
		ck(scl_hold_o, 8'h00);
		rd(8'h66, 8'h04);
		$display("test arbitration done");
	endtask
	task automatic t_tx;
		transmitter_role_i <= 1'h1;
		wb(1'h1, 8'h6a, 8'ha5);
		q = 8'h00;
		repeat (3) begin
			#1 if (tx_start_o === 1'h1) q = 8'h01;
			@(posedge sys_clk_i);
		end
		ck(q, 8'h01);
		ck(tx_byte_o, 8'ha5);
		ev(9'h080, 8'h00);
		ck(scl_hold_o, 8'h01);
		wb(1'h1, 8'h64, 8'h00);
		#1 ck(scl_hold_o, 8'h00);
		$display("test transmit done");
	endtask
	task automatic t_rx;
		int n;
		n = 0;
		wb(1'h1, 8'h64, 8'h20);
		transmitter_role_i <= 1'h0;
		wb(1'h1, 8'h64, 8'h24);
		ev(9'h002, 8'h5a);
		ck(address_ack_o, 8'h01);
		ck(rx_allow_o, 8'h01);
		ev(9'h001, 8'h3c);
		ck(rx_allow_o, 8'h00);
		ev(9'h001, 8'h77);
		rd(8'h6a, 8'h3c);
		ev(9'h001, 8'h77);
		rd(8'h6a, 8'h77);
		repeat (256) begin
			@(posedge sys_clk_i);
			n += scl_tick_o;
		end
		ck(n[7:0], 8'h02);
		$display("test receive done");
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#200000;
		ck(8'h00, 8'h01);
		final_report;
	end
	initial begin
		repeat (8) @(posedge sys_clk_i);
		resetn_i <= 1'h1;
		t_regs;
		t_flags;
		t_gcall;
		t_arb;
		t_tx;
		t_rx;
		final_report;
	end
endmodule // i2c_status_clock_address_regs_tb
`default_nettype wire
